//--- cpu_insn_subset_exec.v
// Purpose: execute a subset of single-word instructions, one per instruction clock
// Assumes: fetch supplies insn_in for the address on pc_out; file registers held here
// Notes: status lives at file address 3 so page bits and flags share one register
`timescale 1ns/1ps
`include "insn_exec_regs.vh"
module cpu_insn_subset_exec #(
	parameter NUM_FILES = 32
)(
	// clock and reset
	input wire sys_clk_in,
	input wire rstn_in,
	// instruction fetch
	input wire [11:0] insn_in,
	output reg [10:0] pc_out,
	// observed state
	output reg [7:0] acc_out,
	output reg [7:0] status_out,
	output reg flush_out
);
	reg [7:0] files_q [0:NUM_FILES-1];
	reg [7:0] acc_q;
	reg [10:0] pc_q;
	reg flush_q;
	reg [7:0] result_d;
	reg write_acc_d;
	reg write_file_d;
	reg set_z_d;
	reg flush_d;
	reg [10:0] pc_d;
	reg [7:0] status_d;
	wire [7:0] file_d [0:NUM_FILES-1];
	wire [11:0] word;
	wire [4:0] faddr;
	wire dest;
	wire [7:0] fval;
	wire [7:0] status_q;
	wire [10:0] pc_inc;
	wire [8:0] jump_target;
	wire [1:0] page_sel;
	wire zero_d;
	wire writes_status;
	wire is_dec_skip;
	wire is_inc_skip;
	wire is_or_file;
	wire is_copy;
	wire is_store;
	wire is_jump;
	wire is_or_lit;
	wire is_skip;
	wire writes_dest;
	integer i;
	genvar g;

	// the word after a taken skip or a jump was fetched for the old flow, so it runs as a no-op
	assign word = flush_q ? `NO_OPERATION_WORD : insn_in;
	assign faddr = word[4:0];
	assign dest = word[5];
	assign fval = files_q[faddr];
	assign status_q = files_q[`STATUS_ADDR];
	assign pc_inc = pc_q + 11'h001;
	assign jump_target = word[8:0];
	assign page_sel = status_q[`STATUS_PAGE_HI:`STATUS_PAGE_LO];
	assign zero_d = (result_d == 8'h00);
	assign writes_status = write_file_d && (faddr == `STATUS_ADDR);

	// opcode decode; the patterns do not overlap, so at most one is high
	assign is_dec_skip = (word[11:6] == `OPC_DECSKIP_6);
	assign is_inc_skip = (word[11:6] == `OPC_INCSKIP_6);
	assign is_or_file = (word[11:6] == `OPC_OR_FILE_6);
	assign is_copy = (word[11:6] == `OPC_COPY_FILE_6);
	assign is_store = (word[11:5] == `OPC_STORE_7);
	assign is_jump = (word[11:9] == `OPC_JUMP_3);
	assign is_or_lit = (word[11:8] == `OPC_ORLIT_4);
	assign is_skip = is_dec_skip | is_inc_skip;
	assign writes_dest = is_skip | is_or_file | is_copy;

	// result of the data-path instructions
	always @*
	begin
		result_d = 8'h00;
		if (is_dec_skip)
			result_d = fval - 8'h01;
		else if (is_inc_skip)
			result_d = fval + 8'h01;
		else if (is_or_file)
			result_d = acc_q | fval;
		else if (is_copy)
			result_d = fval;
		else if (is_store)
			result_d = acc_q;
		else if (is_or_lit)
			result_d = acc_q | word[7:0];
	end

	// destination select: d low writes the accumulator, d high the addressed file
	always @*
	begin
		write_acc_d = 1'b0;
		write_file_d = 1'b0;
		if (writes_dest)
		begin
			write_acc_d = ~dest;
			write_file_d = dest;
		end
		else if (is_store)
			write_file_d = 1'b1;
		else if (is_or_lit)
			write_acc_d = 1'b1;
	end

	// skips, stores and jumps leave every flag alone unless a skip or store writes file 3 itself
	always @*
	begin
		set_z_d = 1'b0;
		if (is_or_file | is_copy | is_or_lit)
			set_z_d = 1'b1;
	end

	// program counter and flush of the stale successor
	always @*
	begin
		flush_d = 1'b0;
		pc_d = pc_inc;
		if (is_skip)
			flush_d = zero_d;
		else if (is_jump)
		begin
			pc_d = {page_sel, jump_target};
			// the successor already fetched is stale, so the jump costs a second cycle
			flush_d = 1'b1;
		end
	end

	// a file write to status and a zero-flag update may meet; the flag is the later effect and wins
	always @*
	begin
		status_d = status_q;
		if (writes_status)
			status_d = result_d;
		if (set_z_d)
			status_d[`STATUS_Z_BIT] = zero_d;
	end

	// next value of every file register
	generate
		for (g = 0; g < NUM_FILES; g = g + 1)
		begin : gen_file
			if (g == `STATUS_ADDR)
			begin : gen_status
				assign file_d[g] = status_d;
			end
			else
			begin : gen_plain
				wire hit = write_file_d && ({27'h0, faddr} == g);
				assign file_d[g] = hit ? result_d : files_q[g];
			end
		end
	endgenerate

	// accumulator, program counter and flush flag
	always @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			acc_q <= `ACC_RESET;
			pc_q <= `PC_RESET;
			flush_q <= 1'b0;
		end
		else
		begin
			pc_q <= pc_d;
			flush_q <= flush_d;
			if (write_acc_d)
				acc_q <= result_d;
		end
	end

	// every file register loads its next value on each edge
	always @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			for (i = 0; i < NUM_FILES; i = i + 1)
				files_q[i] <= (i == `STATUS_ADDR) ? `STATUS_RESET : 8'h00;
		end
		else
		begin
			for (i = 0; i < NUM_FILES; i = i + 1)
				files_q[i] <= file_d[i];
		end
	end

	// status is shown as it stood before this edge, one cycle behind the accumulator
	always @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pc_out <= `PC_RESET;
			acc_out <= `ACC_RESET;
			status_out <= `STATUS_RESET;
			flush_out <= 1'b0;
		end
		else
		begin
			pc_out <= pc_d;
			acc_out <= write_acc_d ? result_d : acc_q;
			status_out <= status_q;
			flush_out <= flush_d;
		end
	end
endmodule

//--- insn_exec_regs.vh
// Purpose: constants for the instruction subset execution core
// Assumes: 12-bit instruction words, baseline-style encodings
// Notes: opcode patterns are compared against the top bits of the word
`ifndef INSN_EXEC_REGS_VH
`define INSN_EXEC_REGS_VH
// 6-bit opcode field, bits 11:6
`define OPC_OR_FILE_6 6'h04
`define OPC_COPY_FILE_6 6'h08
`define OPC_DECSKIP_6 6'h0B
`define OPC_INCSKIP_6 6'h0F
// 7-bit field, bits 11:5, store has d forced to 1
`define OPC_STORE_7 7'h01
// 3-bit field, bits 11:9
`define OPC_JUMP_3 3'h5
// 4-bit field, bits 11:8
`define OPC_ORLIT_4 4'hD
// status register layout, reset values, status address and no-op word
`define STATUS_Z_BIT 2
`define STATUS_PAGE_HI 6
`define STATUS_PAGE_LO 5
`define STATUS_RESET 8'h00
`define ACC_RESET 8'h00
`define PC_RESET 11'h000
`define STATUS_ADDR 5'h03
`define NO_OPERATION_WORD 12'h000
`endif

//--- insn_exec_chk_sva.sv
// Purpose: port checker for the execution core
// Assumes: status_out lags acc_out by one edge
// Notes: bound below the module
`timescale 1ns/1ps
module insn_exec_chk(
	input wire sys_clk_in,
	input wire rstn_in,
	input wire [11:0] insn_in,
	input wire [10:0] pc_out,
	input wire [7:0] acc_out,
	input wire [7:0] status_out,
	input wire flush_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	wire jmp = !flush_out && insn_in[11:9] == 3'h5;
	wire orl = !flush_out && insn_in[11:8] == 4'hD;
	wire cpy = !flush_out && insn_in[11:5] == 7'h10;
	wire sto = !flush_out && insn_in[11:5] == 7'h01;
	wire skp = !flush_out && !insn_in[5] && (insn_in[11:6] == 6'h0B || insn_in[11:6] == 6'h0F);
	chk_jump_target: assert property (jmp |=> flush_out && pc_out[8:0] == $past(insn_in[8:0]))
		else $error("jump target");
	chk_pc_step: assert property (!jmp |=> pc_out == $past(pc_out) + 11'h001)
		else $error("pc step");
	chk_orlit_acc: assert property (orl |=> acc_out == ($past(acc_out) | $past(insn_in[7:0])))
		else $error("or literal");
	chk_zero_flag: assert property ((orl || cpy) |=> ##1 status_out[2] == ($past(acc_out) == 8'h00))
		else $error("zero flag");
	chk_store_keep: assert property (sto |=> acc_out == $past(acc_out) && !flush_out)
		else $error("store");
	chk_skip_flush: assert property (skp |=> flush_out == (acc_out == 8'h00))
		else $error("skip flush");
	chk_flush_nop: assert property (flush_out |=> !flush_out && acc_out == $past(acc_out))
		else $error("flush nop");
	chk_skip_flags: assert property (skp |=> ##1 status_out[2] == $past(status_out[2]))
		else $error("skip flags");
	chk_jump_page: assert property (jmp |=> pc_out[10:9] == status_out[6:5])
		else $error("jump page");
	chk_jump_flags: assert property (jmp |=> ##1 status_out == $past(status_out))
		else $error("jump flags");
	cover property (jmp);
	cover property (jmp ##1 pc_out[10:9] != 2'b00);
	cover property (skp ##1 flush_out);
	cover property (orl);
endmodule
bind cpu_insn_subset_exec insn_exec_chk u_insn_exec_chk(
	.sys_clk_in(sys_clk_in),
	.rstn_in(rstn_in),
	.insn_in(insn_in),
	.pc_out(pc_out),
	.acc_out(acc_out),
	.status_out(status_out),
	.flush_out(flush_out)
);

//--- cpu_insn_subset_exec_test.sv
// Purpose: directed run of the execution core
// Assumes: outputs settle 1 ns after each edge
// Notes: driver queues expected {pc, flush, acc}, watcher compares
`timescale 1ns/1ps
module cpu_insn_subset_exec_test;
	reg sys_clk_in = 0;
	reg rstn_in = 0;
	reg [11:0] insn_in = 12'h000;
	wire [10:0] pc_out;
	wire [7:0] acc_out;
	wire [7:0] status_out;
	wire flush_out;
	logic [19:0] exp_q[$];
	integer n_mismatch = 0;
	integer num_checks = 0;
	integer seed = 32'h6575;
	reg [31:0] r;
	// one idle no-operation runs between reset release and the first step
	reg [10:0] pc_m = 11'h001;
	always #5 sys_clk_in = ~sys_clk_in;
	cpu_insn_subset_exec u_cpu_insn_subset_exec(.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.insn_in(insn_in), .pc_out(pc_out), .acc_out(acc_out), .status_out(status_out),
		.flush_out(flush_out));
	task chk(input [19:0] seen, input [19:0] want);
		num_checks = num_checks + 1;
		if (seen !== want)
		begin
			n_mismatch = n_mismatch + 1;
			$display("unexpected pc_flush_acc exp %h seen %h", want, seen);
		end
	endtask
	task step(input [11:0] w, input [8:0] e);
		@(negedge sys_clk_in);
		insn_in = w;
		pc_m = pc_m + 11'h001;
		exp_q.push_back({pc_m, e});
	endtask
	// t carries the page the bench stored into status above the 9-bit target
	task jump(input [10:0] t, input [7:0] a);
		@(negedge sys_clk_in);
		insn_in = {3'h5, t[8:0]};
		pc_m = t;
		exp_q.push_back({t, 1'b1, a});
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge sys_clk_in)
		if (exp_q.size() > 0)
		begin
			#1;
			chk({pc_out, flush_out, acc_out}, exp_q.pop_front());
		end
	initial
	begin
		r = $random(seed);
		repeat (3) @(negedge sys_clk_in);
		rstn_in = 1;
		step(12'hD01, 9'h001);
		step(12'h029, 9'h001);
		// skip to zero: the following word must be dropped
		step(12'h2C9, 9'h100);
		step(12'hDFF, 9'h000);
		step(12'h3E9, 9'h000);
		jump({2'b00, r[8:0]}, 8'h00);
		step(12'hDFF, 9'h000);
		step({4'hD, r[23:16]}, {1'b0, r[23:16]});
		step(12'h109, {1'b0, r[23:16] | 8'h02});
		step(12'h209, 9'h002);
		step(12'hDFF, 9'h0FF);
		step(12'h02A, 9'h0FF);
		step(12'h3CA, 9'h100);
		step(12'hD0F, 9'h000);
		step(12'h22A, 9'h000);
		step(12'hD60, 9'h060);
		step(12'h023, 9'h060);
		step(12'h129, 9'h060);
		step(12'h209, 9'h062);
		jump({2'b11, r[17:9]}, 8'h62);
		step(12'hDFF, 9'h062);
		step(12'hD01, 9'h063);
		repeat (2) @(negedge sys_clk_in);
		$display("instruction sequence done");
		results;
	end
endmodule
